// [hw/rl_pkg.sv]
// shared constants, types and register map of the remote I/O link slave
package rl_pkg;
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned BAUD_HZ     = 187_500;
    localparam int unsigned OVS         = 16;
    localparam int unsigned OVS_DIV     = CLK_HZ / (BAUD_HZ * OVS);
    localparam int unsigned BLINK_MS    = 250;
    localparam int unsigned BLINK_CYC   = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned LINK_TMO_MS = 50;
    localparam int unsigned LINK_TMO_CYC = CLK_HZ / 1000 * LINK_TMO_MS;
    localparam int unsigned GAP_US      = 100;
    localparam int unsigned GAP_CYC     = CLK_HZ / 1_000_000 * GAP_US;
    localparam int unsigned TURN_TICKS  = OVS;

    // master frame: addr,~addr, ctrl,~ctrl, 4 data pairs, check byte
    localparam int unsigned MFRM_LEN    = 13;
    // reply frame: 4 data pairs, check byte
    localparam int unsigned RFRM_LEN    = 9;
    localparam int unsigned IO_POINTS   = 32;
    localparam int unsigned WORD_STEP   = 4;
    localparam int unsigned CTRL_RUN_BIT = 0;

    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_OUT      = 8'h08;
    localparam logic [7:0] REG_IN       = 8'h0C;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;

    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_CLR_BIT = 1;
    localparam int unsigned CTRL_SEL_LSB = 4;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0001;

    localparam int unsigned ST_RDY_BIT  = 0;
    localparam int unsigned ST_RUN_BIT  = 1;
    localparam int unsigned ST_ERR_BIT  = 2;
    localparam int unsigned ST_OFS_LSB  = 8;

    localparam int unsigned INT_W        = 3;
    localparam int unsigned INT_FRAME    = 0;
    localparam int unsigned INT_ERR      = 1;
    localparam int unsigned INT_RECOV    = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] word_sel;
        logic       hold_clr;
        logic       enable;
    } rl_cfg_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_TURN = 2'b01,
        TX_SEND = 2'b10
    } rl_tx_state_type;
endpackage : rl_pkg

// [hw/rl_rx.sv]
// byte receiver for the serial line, oversampled by an enable tick
`timescale 1ns/1ps
`default_nettype none
module rl_rx (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       tick,
    input  wire logic       rx_pin,
    output var  logic       byte_valid,
    output var  logic [7:0] byte_data,
    output var  logic       frame_err
);
    logic       sync1_r;
    logic       sync2_r;
    logic       busy_r;
    logic [3:0] ph_r;
    logic [3:0] bit_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= rx_pin;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_r     <= 1'b0;
            ph_r       <= 4'h0;
            bit_r      <= 4'h0;
            byte_data  <= 8'h00;
            byte_valid <= 1'b0;
            frame_err  <= 1'b0;
        end else begin
            byte_valid <= 1'b0;
            frame_err  <= 1'b0;
            if (tick) begin
                if (!busy_r) begin
                    if (!sync2_r) begin
                        busy_r <= 1'b1;
                        ph_r   <= 4'h0;
                        bit_r  <= 4'h0;
                    end
                end else begin
                    ph_r <= ph_r + 4'h1;
                    // sample at mid bit
                    if (ph_r == 4'h7) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h0) begin
                            if (sync2_r) begin
                                busy_r <= 1'b0;
                            end
                        end else if (bit_r == 4'h9) begin
                            busy_r <= 1'b0;
                            if (sync2_r) begin
                                byte_valid <= 1'b1;
                            end else begin
                                frame_err <= 1'b1;
                            end
                        end else begin
                            byte_data <= {sync2_r, byte_data[7:1]};
                        end
                    end
                end
            end
        end
    end
endmodule : rl_rx
`default_nettype wire

// [hw/rl_link_slave.sv]
// remote I/O link slave: serial exchange with master, local word registers
// Summary of operation
// [RULE1] The ready lamp is lit whenever the unit is powered and out of reset.
// [RULE2] The run lamp is lit only while the master reports operating mode.
// [RULE3] The error lamp is steady on during a link error and flashes otherwise.
// [RULE4] The error lamp goes back to flashing by itself once good frames return.
// [RULE5] On a link error the master word is held if hold-clear is off, else zeroed.
// [RULE6] The unit takes output words 4n,4n+1 and returns input words 4n+2,4n+3.
// [RULE7] Word-select bits 0,1,2 weigh 4, 8 and 16 words of the offset.
// [RULE8] The master only sees slaves powered up before it starts.
// [RULE9] Every byte is sent twice, second inverted, plus a check byte, and compared.
// [RULE10] The unit carries 32 input points and 32 output points.
// [RULE11] Locally the unit looks like two output words and two input words.
// [RULE12] Each good cycle copies master words out and local words back.
`timescale 1ns/1ps
`default_nettype none
module rl_link_slave
    import rl_pkg::*;
#(
    parameter int unsigned BLINK_CNT = BLINK_CYC,
    parameter int unsigned TMO_CNT   = LINK_TMO_CYC,
    parameter int unsigned GAP_CNT   = GAP_CYC
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        link_rx,
    output var  logic        link_tx,
    output var  logic        link_oe,
    output var  logic [31:0] out_words,
    output var  logic        led_ready,
    output var  logic        led_run,
    output var  logic        led_err,
    output var  logic        irq
);
    rl_cfg_type             cfg;
    logic [31:0]            ctrl_r;
    logic [IO_POINTS-1:0]   in_words_r;
    logic [INT_W-1:0]       int_stat_r;
    logic [INT_W-1:0]       int_mask_r;
    logic [INT_W-1:0]       int_ev;
    logic [7:0]             my_ofs;
    logic [7:0]             ovs_cnt_r;
    logic                   tick_r;
    logic                   rx_valid;
    logic [7:0]             rx_data;
    logic                   rx_ferr;
    logic [7:0]             mbuf_r [MFRM_LEN];
    logic [3:0]             midx_r;
    logic [31:0]            gap_cnt_r;
    logic [31:0]            tmo_cnt_r;
    logic [31:0]            blink_cnt_r;
    logic                   blink_r;
    logic                   err_r;
    logic                   run_r;
    logic                   frm_done;
    logic                   frm_ok;
    logic                   frm_ours;
    logic                   frm_bad;
    logic                   tmo_hit;
    logic [7:0]             rbuf [RFRM_LEN];
    rl_tx_state_type        tx_st_r;
    logic [3:0]             tx_ph_r;
    logic [3:0]             tx_bit_r;
    logic [3:0]             tx_byte_r;
    logic                   aw_got_r;
    logic                   w_got_r;
    logic [7:0]             aw_addr_r;
    logic [31:0]            w_data_r;
    logic [3:0]             w_strb_r;
    logic                   wr_fire;

    assign cfg = '{word_sel: ctrl_r[CTRL_SEL_LSB +: 3],
                   hold_clr: ctrl_r[CTRL_CLR_BIT],
                   enable:   ctrl_r[CTRL_EN_BIT]};

    // offset of the master output pair; input pair sits two words above
    assign my_ofs = {3'h0, cfg.word_sel, 2'h0}; // RULE6 RULE7

    // 16x bit-rate enable; the rate is off by about 1 percent, well inside
    // what a mid-bit sampler tolerates
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ovs_cnt_r <= 8'h00;
            tick_r    <= 1'b0;
        end else if (ovs_cnt_r == 8'(OVS_DIV - 1)) begin
            ovs_cnt_r <= 8'h00;
            tick_r    <= 1'b1;
        end else begin
            ovs_cnt_r <= ovs_cnt_r + 8'h01;
            tick_r    <= 1'b0;
        end
    end

    rl_rx u_rx (
        .clock      (clock),
        .resetn     (resetn),
        .tick       (tick_r),
        .rx_pin     (link_rx),
        .byte_valid (rx_valid),
        .byte_data  (rx_data),
        .frame_err  (rx_ferr)
    );

    // bytes arriving while we drive the line are our own echo
    logic rx_take;
    assign rx_take = rx_valid && cfg.enable && (tx_st_r == TX_IDLE);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            midx_r    <= 4'h0;
            gap_cnt_r <= 32'h0;
        end else if (rx_take) begin
            gap_cnt_r <= 32'h0;
            midx_r    <= (midx_r == 4'(MFRM_LEN - 1)) ? 4'h0
                                                      : midx_r + 4'h1;
        end else if (gap_cnt_r == 32'(GAP_CNT - 1)) begin
            // a quiet line starts a new frame
            midx_r <= 4'h0;
        end else begin
            gap_cnt_r <= gap_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rx_take) begin
            mbuf_r[midx_r] <= rx_data;
        end
    end

    assign frm_done = rx_take && (midx_r == 4'(MFRM_LEN - 1));

    always_comb begin
        logic [7:0] bcc;
        logic       pairs_ok;
        bcc      = 8'h00;
        pairs_ok = 1'b1;
        for (int i = 0; i < MFRM_LEN - 1; i++) begin
            bcc = bcc ^ mbuf_r[i];
        end
        for (int i = 0; i < (MFRM_LEN - 1) / 2; i++) begin
            if (mbuf_r[2*i] != ~mbuf_r[2*i+1]) begin
                pairs_ok = 1'b0;
            end
        end
        frm_ok   = pairs_ok && (bcc == rx_data); // RULE9
        frm_ours = frm_ok && (mbuf_r[0] == my_ofs); // RULE6
    end

    assign frm_bad = (frm_done && !frm_ok) || (rx_ferr && cfg.enable)
                     || (rx_take && midx_r[0]
                         && (rx_data != ~mbuf_r[midx_r - 4'h1])); // RULE9
    assign tmo_hit = (tmo_cnt_r == 32'(TMO_CNT - 1));

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tmo_cnt_r <= 32'h0;
        end else if ((frm_done && frm_ours) || !cfg.enable) begin
            tmo_cnt_r <= 32'h0;
        end else if (!tmo_hit) begin
            tmo_cnt_r <= tmo_cnt_r + 32'h1;
        end
    end

    // error state: set by a bad frame or silence, cleared by a good frame addressed to this unit
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            err_r <= 1'b0;
            run_r <= 1'b0;
        end else if (frm_done && frm_ours) begin
            err_r <= 1'b0; // RULE4
            run_r <= mbuf_r[2][CTRL_RUN_BIT]; // RULE2
        end else if (frm_bad || tmo_hit) begin
            err_r <= 1'b1; // RULE3
            run_r <= 1'b0;
        end
    end

    // words written by the master toward the local controller
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out_words <= '0;
        end else if (frm_done && frm_ours) begin
            out_words <= {mbuf_r[10], mbuf_r[8], mbuf_r[6], mbuf_r[4]}; // RULE12 RULE10
        end else if ((frm_bad || tmo_hit) && cfg.hold_clr) begin
            out_words <= '0; // RULE5
        end
    end

    always_comb begin
        logic [7:0] bcc;
        bcc = 8'h00;
        for (int i = 0; i < 4; i++) begin
            rbuf[2*i]   = in_words_r[8*i +: 8]; // RULE12 RULE10
            rbuf[2*i+1] = ~in_words_r[8*i +: 8]; // RULE9
            bcc = bcc ^ in_words_r[8*i +: 8] ^ ~in_words_r[8*i +: 8];
        end
        rbuf[RFRM_LEN-1] = bcc;
    end

    // reply: one bit time of turnaround, then 8N1 bytes, line released after
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_st_r   <= TX_IDLE;
            tx_ph_r   <= 4'h0;
            tx_bit_r  <= 4'h0;
            tx_byte_r <= 4'h0;
            link_tx   <= 1'b1;
            link_oe   <= 1'b0;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    link_oe <= 1'b0;
                    link_tx <= 1'b1;
                    if (frm_done && frm_ours) begin
                        tx_st_r <= TX_TURN; // RULE6
                        tx_ph_r <= 4'h0;
                    end
                end
                TX_TURN: begin
                    if (tick_r) begin
                        tx_ph_r <= tx_ph_r + 4'h1;
                        if (tx_ph_r == 4'(TURN_TICKS - 1)) begin
                            tx_st_r   <= TX_SEND;
                            tx_bit_r  <= 4'h0;
                            tx_byte_r <= 4'h0;
                            link_oe   <= 1'b1;
                            link_tx   <= 1'b0;
                        end
                    end
                end
                TX_SEND: begin
                    if (tick_r) begin
                        tx_ph_r <= tx_ph_r + 4'h1;
                        if (tx_ph_r == 4'(OVS - 1)) begin
                            if (tx_bit_r == 4'h9) begin
                                tx_bit_r <= 4'h0;
                                if (tx_byte_r == 4'(RFRM_LEN - 1)) begin
                                    tx_st_r <= TX_IDLE;
                                    link_oe <= 1'b0;
                                    link_tx <= 1'b1;
                                end else begin
                                    tx_byte_r <= tx_byte_r + 4'h1;
                                    link_tx   <= 1'b0;
                                end
                            end else begin
                                tx_bit_r <= tx_bit_r + 4'h1;
                                link_tx  <= (tx_bit_r == 4'h8) ? 1'b1
                                          : rbuf[tx_byte_r][tx_bit_r[2:0]];
                            end
                        end
                    end
                end
                default: begin
                    tx_st_r <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            blink_cnt_r <= 32'h0;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r == 32'(BLINK_CNT - 1)) begin
            blink_cnt_r <= 32'h0;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            led_ready <= 1'b0;
            led_run   <= 1'b0;
            led_err   <= 1'b0;
        end else begin
            led_ready <= 1'b1; // RULE1
            led_run   <= run_r; // RULE2
            led_err   <= err_r ? 1'b1 : blink_r; // RULE3 RULE4
        end
    end

    // ---- register bus ----
    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r inside {REG_CTRL, REG_STATUS,
                                 REG_OUT, REG_IN, REG_INT_STAT, REG_INT_MASK})
                                ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_r     <= CTRL_RST;
            in_words_r <= '0;
            int_mask_r <= '0;
        end else if (wr_fire) begin
            if (aw_addr_r == REG_CTRL) begin
                ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
            end
            if (aw_addr_r == REG_IN) begin
                in_words_r <= merge(in_words_r, w_data_r, w_strb_r); // RULE11
            end
            if (aw_addr_r == REG_INT_MASK && w_strb_r[0]) begin
                int_mask_r <= w_data_r[INT_W-1:0];
            end
        end
    end

    always_comb begin
        int_ev            = '0;
        int_ev[INT_FRAME] = frm_done && frm_ours;
        int_ev[INT_ERR]   = !err_r && (frm_bad || tmo_hit) && !int_ev[INT_FRAME];
        int_ev[INT_RECOV] = err_r && frm_done && frm_ours;
    end

    // an event in the clearing cycle survives the clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            int_stat_r <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_fire && aw_addr_r == REG_INT_STAT && w_strb_r[0]) begin
                int_stat_r <= (int_stat_r & ~w_data_r[INT_W-1:0]) | int_ev;
            end else begin
                int_stat_r <= int_stat_r | int_ev;
            end
            irq <= |(int_stat_r & int_mask_r);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL:     s_axi_rdata <= ctrl_r;
                REG_STATUS:   s_axi_rdata <= {16'h0, my_ofs, 5'h0,
                                              err_r, run_r, 1'b1};
                REG_OUT:      s_axi_rdata <= out_words;
                REG_IN:       s_axi_rdata <= in_words_r;
                REG_INT_STAT: s_axi_rdata <= {29'h0, int_stat_r};
                REG_INT_MASK: s_axi_rdata <= {29'h0, int_mask_r};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule : rl_link_slave
`default_nettype wire

// [sim/rl_link_slave_props.sv]
// checker on the link slave ports
`timescale 1ns/1ps
`default_nettype none
module rl_link_slave_props
    import rl_pkg::*;
#(parameter int unsigned BLINK_CNT = 20) (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        link_tx,
    input wire logic        link_oe,
    input wire logic        led_ready,
    input wire logic        led_err
);
    logic [15:0] lo_r, oe_r;
    // run lengths of lamp-off and line-drive spells
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lo_r <= 16'h0000;
            oe_r <= 16'h0000;
        end else begin
            lo_r <= led_err ? 16'h0000 : lo_r + 16'h0001;
            oe_r <= link_oe ? oe_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_ready_lamp: assert property ($past(resetn) |-> led_ready)
        else $error("ready lamp off");
    a_blink_rate: assert property (lo_r <= BLINK_CNT + 2)
        else $error("error lamp not flashing");
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read response");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_line_idle: assert property (!link_oe |-> link_tx)
        else $error("tx not idle high");
    a_reply_start: assert property ($rose(link_oe) |-> !link_tx)
        else $error("reply lacks start bit");
    a_reply_len: assert property ($fell(link_oe) |->
        $past(oe_r) inside {[16'hB798:16'hBB80]}) else $error("reply length");
endmodule : rl_link_slave_props
bind rl_link_slave rl_link_slave_props #(.BLINK_CNT(BLINK_CNT)) u_props (
    .clock, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .link_tx, .link_oe,
    .led_ready, .led_err);
`default_nettype wire

// [sim/rl_master_model.sv]
// behavioural remote master sending frames on the serial line
`timescale 1ns/1ps
`default_nettype none
module rl_master_model (
    input  wire logic clock,
    output var  logic m_tx,
    output var  logic m_oe
);
    initial begin
        m_tx = 1'b1;
        m_oe = 1'b0;
    end
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            m_tx <= i == 0 ? 1'b0 : (i == 9 ? 1'b1 : b[i - 1]);
            repeat (528) @(posedge clock);
        end
    endtask : send_byte
    // bad spoils the inverted copy of the address byte and ends the frame
    task automatic send_frame(input logic [47:0] v, input logic bad);
        logic [7:0] bcc = 8'h00;
        m_oe <= 1'b1;
        for (int k = 0; k < 6 && !(bad && k > 0); k++) begin
            send_byte(v[8*k +: 8]);
            send_byte(~v[8*k +: 8] ^ {7'h00, bad});
            bcc = bcc ^ 8'hFF;
        end
        if (!bad)
            send_byte(bcc);
        m_oe <= 1'b0;
    endtask : send_frame
endmodule : rl_master_model
`default_nettype wire

// [sim/tb_rl_link_slave.sv]
// bench for the remote I/O link slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t %h %h", $time, (a), (b)); end end
module tb_rl_link_slave
    import rl_pkg::*;
;
    localparam int unsigned TMO_P = 12000;
    logic        clock = 1'b0, resetn = 1'b0, hc, awr, wrd, bv, arr, rv;
    logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, bready = 1'b0, m_tx;
    logic        rready = 1'b0, ltx, loe, lrdy, lrun, lerr, irq, m_oe, line;
    logic [1:0]  br, rr, r;
    logic [2:0]  n;
    logic [7:0]  ad = 8'h00;
    logic [31:0] wd = 32'h0, q, dat, inw, rdt, ow, rb;
    int          miscompares = 0, checked = 0, k;
    rl_link_slave #(.BLINK_CNT(20), .TMO_CNT(TMO_P), .GAP_CNT(5600)) dut (
        .clock, .resetn, .s_axi_awaddr(ad), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ad),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .link_rx(line), .link_tx(ltx), .link_oe(loe), .out_words(ow),
        .led_ready(lrdy), .led_run(lrun), .led_err(lerr), .irq);
    rl_master_model mdl (.clock, .m_tx, .m_oe);
    // line pulled up while nobody drives it
    assign line = loe ? ltx : (m_oe ? m_tx : 1'b1);
    always #5 clock = ~clock;
    function automatic logic [7:0] exp_ofs(input logic [2:0] s);
        return {3'h0, s, 2'h0};
    endfunction : exp_ofs
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic need(input logic ok);
        if (!ok) begin
            miscompares++;
            close_out();
        end
    endtask : need
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clock);
        ad <= a;
        wd <= d;
        awv <= w;
        wv <= w;
        arv <= !w;
        bready <= w;
        rready <= !w;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (arr) arv <= 1'b0;
            q = rdt;
            r = w ? br : rr;
            if (w ? bv : rv) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        need(i < 40);
    endtask : bus
    initial begin
        void'($urandom(32'h5220));
        n = 3'($urandom);
        hc = 1'($urandom);
        dat = $urandom;
        inw = $urandom;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK(lrdy, 1'b1)
        bus(0, REG_CTRL, 32'h0);
        `CHK(q, CTRL_RST)
        bus(1, REG_CTRL, {25'h0, n, 2'h0, hc, 1'b1});
        bus(1, REG_IN, inw);
        bus(1, REG_INT_MASK, 32'h3);
        bus(0, REG_IN, 32'h0);
        `CHK(q, inw)
        bus(0, 8'h18, 32'h0);
        `CHK({r, q}, {RESP_SLVERR, 32'h0})
        bus(0, REG_STATUS, 32'h0);
        `CHK(q[15:8], exp_ofs(n))
        $display("done regs");
        mdl.send_frame({dat, 8'h01, exp_ofs(n)}, 1'b1);
        bus(0, REG_STATUS, 32'h0);
        `CHK({q[ST_ERR_BIT], irq, lerr}, 3'h7)
        bus(1, REG_INT_STAT, 32'h7);
        $display("done bad pair");
        repeat (5600) @(posedge clock);
        mdl.send_frame({dat, 8'h01, exp_ofs(n)}, 1'b0);
        for (k = 0; k < 2000 && loe !== 1'b1; k++) @(posedge clock);
        need(loe === 1'b1);
        `CHK(ow, dat)
        `CHK({lrun, irq}, 2'h3)
        for (k = 0; k < 20; k++) begin
            repeat (k ? 528 : 264) @(posedge clock);
            rb[k] = ltx;
        end
        `CHK(rb[19:0], {1'b1, ~inw[7:0], 2'b01, inw[7:0], 1'b0})
        bus(1, REG_INT_STAT, 32'h1);
        bus(0, REG_INT_STAT, 32'h0);
        `CHK({q, irq}, {32'h4, 1'b0})
        $display("done good frame");
        q = 32'h0;
        for (k = 0; k < 300 && q[ST_ERR_BIT] !== 1'b1; k++) begin
            repeat (200) @(posedge clock);
            bus(0, REG_STATUS, 32'h0);
        end
        need(q[ST_ERR_BIT] === 1'b1);
        `CHK(ow, hc ? 32'h0 : dat)
        `CHK({lrun, irq, lerr}, 3'h3)
        $display("done timeout");
        close_out();
    end
endmodule : tb_rl_link_slave
`default_nettype wire
